/* logic/ecc_pkg.sv */
// command codes, login classes and actions for the link service classifier
package ecc_pkg;
  localparam logic [7:0] CMD_DIAG_REG = 8'h19;
  localparam logic [7:0] CMD_LEGACY_RSVD = 8'h14;
  localparam logic [7:0] CMD_PROC_LOGIN = 8'h20;
  localparam logic [7:0] CMD_PROC_LOGOUT = 8'h21;
  localparam logic [7:0] CMD_PROC_TEST = 8'h23;
  localparam logic [7:0] CMD_TP_LOGOUT = 8'h24;
  localparam logic [7:0] CMD_NPORT_DISC = 8'h50;
  localparam logic [7:0] CMD_FPORT_DISC = 8'h51;
  localparam logic [7:0] CMD_ADDR_DISC = 8'h52;
  localparam logic [7:0] CMD_BUF_REPORT = 8'h58;
  localparam logic [7:0] CMD_ADDR_NOTIFY = 8'h60;
  localparam logic [7:0] CMD_STATE_NOTIFY = 8'h61;
  localparam logic [7:0] CMD_STATE_REG = 8'h62;
  localparam logic [7:0] CMD_ULP_REPORT = 8'h63;
  localparam logic [7:0] CMD_CLK_REQ = 8'h68;
  localparam logic [7:0] CMD_CLK_UPD = 8'h69;
  localparam logic [7:0] CMD_LOOP_INIT = 8'h70;
  localparam logic [7:0] CMD_LOOP_CTRL_OLD = 8'h71;
  localparam logic [7:0] CMD_LOOP_STATUS = 8'h72;
  localparam logic [7:0] CMD_VENDOR = 8'h77;
  localparam logic [7:0] CMD_NODE_ID = 8'h78;
  localparam logic [7:0] CMD_INC_FIRST = 8'h79;
  localparam logic [7:0] CMD_INC_LAST = 8'h7d;
  localparam logic [7:0] CMD_SEC_QUERY = 8'h7e;
  localparam logic [7:0] CMD_VFAB_PARAM = 8'h7f;
  localparam logic [7:0] CMD_KEEP_ALIVE = 8'h80;
  localparam logic [7:0] CMD_CABLE_BEACON = 8'h81;
  localparam logic [7:0] CMD_AUTH = 8'h90;
  localparam logic [7:0] CMD_FAB_CHANGE = 8'h97;
  localparam logic [7:0] CMD_TOPO_FIRST = 8'ha0;
  localparam logic [7:0] CMD_TOPO_LAST = 8'ha6;
  localparam logic [7:0] CMD_PRIO_QUERY = 8'hb0;
  localparam logic [7:0] CMD_VE_MAP = 8'hb1;
  localparam logic [23:0] FABRIC_CTRL_ID = 24'hfffffd;
  localparam logic [23:0] FPORT_CTRL_ID = 24'hfffffe;
  localparam int CODE_MSB = 31;
  localparam int CODE_LSB = 24;

  typedef enum logic [2:0] {
    LG_NO = 3'h0,
    LG_YES = 3'h1,
    LG_NA = 3'h2,
    LG_COND = 3'h3,
    LG_EXT = 3'h4,
    LG_NO_FAB = 3'h5
  } ecc_login_t;

  typedef enum logic [2:0] {
    ACT_NONE = 3'h0,
    ACT_DISPATCH = 3'h1,
    ACT_ABORT = 3'h2,
    ACT_LOGO_RJT = 3'h3,
    ACT_DISCARD = 3'h4,
    ACT_UNRECOG = 3'h5
  } ecc_action_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_COLLECT = 1'b1
  } ecc_state_t;
endpackage

/* logic/ecc_code_decode.sv */
// command code lookup: known, login class, payload format
module ecc_code_decode (
  // code in
  input wire logic [7:0] code,
  // classification out
  output logic known,
  output ecc_pkg::ecc_login_t loginCls,
  output logic tlv,
  output logic obsolete,
  output logic vendor
);
  always_comb begin
    known = 1'b1;
    loginCls = ecc_pkg::LG_NO;
    tlv = 1'b0;
    obsolete = 1'b0;
    vendor = 1'b0;
    unique case (code)
      ecc_pkg::CMD_DIAG_REG: begin
        loginCls = ecc_pkg::LG_NO_FAB;
        tlv = 1'b1;
      end
      ecc_pkg::CMD_PROC_LOGIN, ecc_pkg::CMD_PROC_LOGOUT, ecc_pkg::CMD_PROC_TEST,
      ecc_pkg::CMD_TP_LOGOUT: loginCls = ecc_pkg::LG_YES;
      ecc_pkg::CMD_NPORT_DISC, ecc_pkg::CMD_FPORT_DISC,
      ecc_pkg::CMD_ADDR_DISC: loginCls = ecc_pkg::LG_YES;
      ecc_pkg::CMD_BUF_REPORT, ecc_pkg::CMD_ULP_REPORT: loginCls = ecc_pkg::LG_YES;
      ecc_pkg::CMD_ADDR_NOTIFY, ecc_pkg::CMD_STATE_NOTIFY, ecc_pkg::CMD_STATE_REG,
      ecc_pkg::CMD_CLK_REQ, ecc_pkg::CMD_CLK_UPD: loginCls = ecc_pkg::LG_NO;
      ecc_pkg::CMD_LOOP_INIT, ecc_pkg::CMD_LOOP_STATUS: loginCls = ecc_pkg::LG_NO;
      ecc_pkg::CMD_LOOP_CTRL_OLD: obsolete = 1'b1;
      ecc_pkg::CMD_VENDOR: begin
        loginCls = ecc_pkg::LG_NA;
        vendor = 1'b1;
      end
      ecc_pkg::CMD_NODE_ID: loginCls = ecc_pkg::LG_NO;
      ecc_pkg::CMD_SEC_QUERY, ecc_pkg::CMD_KEEP_ALIVE, ecc_pkg::CMD_CABLE_BEACON,
      ecc_pkg::CMD_FAB_CHANGE: loginCls = ecc_pkg::LG_NO;
      ecc_pkg::CMD_VFAB_PARAM: loginCls = ecc_pkg::LG_NA;
      ecc_pkg::CMD_AUTH: loginCls = ecc_pkg::LG_EXT;
      ecc_pkg::CMD_PRIO_QUERY: tlv = 1'b1;
      ecc_pkg::CMD_VE_MAP: begin
        loginCls = ecc_pkg::LG_COND;
        tlv = 1'b1;
      end
      default: begin
        if (code >= ecc_pkg::CMD_INC_FIRST && code <= ecc_pkg::CMD_INC_LAST) begin
          loginCls = ecc_pkg::LG_YES;
        end else if (code >= ecc_pkg::CMD_TOPO_FIRST && code <= ecc_pkg::CMD_TOPO_LAST) begin
          loginCls = ecc_pkg::LG_YES;
        end else begin
          // the legacy code falls here too and is never assigned
          known = 1'b0;
        end
      end
    endcase
  end
endmodule // ecc_code_decode

/* logic/ecc_login_resolve.sv */
// resolves login need and login standing from class and addresses
module ecc_login_resolve #(
  parameter int RX_SIZE_W = 12
) (
  // command and addressing
  input wire ecc_pkg::ecc_login_t loginCls,
  input wire logic [23:0] srcId,
  input wire logic [23:0] dstId,
  // login state
  input wire logic srcLoggedIn,
  input wire logic fabricLoggedIn,
  input wire logic authNeedsLogin,
  input wire logic [RX_SIZE_W-1:0] portRxSize,
  input wire logic [RX_SIZE_W-1:0] fabricRxSize,
  // verdict
  output logic needLogin,
  output logic loggedOk,
  output logic implicitLogin,
  output logic [RX_SIZE_W-1:0] rxSize
);
  logic fabricAddr;

  assign fabricAddr = (srcId == ecc_pkg::FABRIC_CTRL_ID) || (dstId == ecc_pkg::FABRIC_CTRL_ID);
  // for the conditional class, only an F_Port controller destination waives login
  assign needLogin = (loginCls == ecc_pkg::LG_YES)
    || ((loginCls == ecc_pkg::LG_COND) && (dstId != ecc_pkg::FPORT_CTRL_ID))
    || ((loginCls == ecc_pkg::LG_EXT) && authNeedsLogin);
  assign implicitLogin = (loginCls == ecc_pkg::LG_NO_FAB) && fabricAddr && fabricLoggedIn;
  assign loggedOk = srcLoggedIn || implicitLogin;
  assign rxSize = implicitLogin ? fabricRxSize : portRxSize;
endmodule // ecc_login_resolve

/* logic/ecc_classifier.sv */
// link service request classifier: code decode, login check, initiative check
// Contract
// - command code comes from payload word zero
// - process login group needs login, non-TLV
// - discovery commands need login, non-TLV
// - buffer and type reports need login
// - notifications and clock sync need no login
// - loop init/status no login; obsolete; vendor
// - node id free; incident group needs login
// - misc free; fabric params n/a; auth external
// - topology map commands need login, non-TLV
// - 19h, B0h, B1h are TLV commands
// - conditional login waived for F_Port controller
// - fabric login implies port login for 19h to or from the fabric controller
// - code 14h stays reserved forever
// - no initiative handover aborts exchange
// - unlogged sender: logout/reject, else discard
module ecc_classifier #(
  parameter int RX_SIZE_W = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // request words from the framing layer
  input wire logic wordValid,
  input wire logic [31:0] wordData,
  input wire logic firstWord,
  input wire logic seqEnd,
  input wire logic siXfer,
  input wire logic [23:0] srcId,
  input wire logic [23:0] dstId,
  input wire logic replyDefined,
  // login state of the sender
  input wire logic srcLoggedIn,
  input wire logic fabricLoggedIn,
  input wire logic authNeedsLogin,
  input wire logic [RX_SIZE_W-1:0] portRxSize,
  input wire logic [RX_SIZE_W-1:0] fabricRxSize,
  // classification result
  output logic resValid,
  output logic [7:0] resCode,
  output logic resKnown,
  output logic resNeedLogin,
  output logic resTlv,
  output logic resObsolete,
  output logic resVendor,
  output logic resImplicit,
  output logic [RX_SIZE_W-1:0] resRxSize,
  output ecc_pkg::ecc_action_t resAction,
  output logic busy
);
  typedef struct packed {
    ecc_pkg::ecc_state_t st;
    logic [7:0] code;
    logic [23:0] src;
    logic [23:0] dst;
    logic valid;
    logic [7:0] outCode;
    logic known;
    logic needLogin;
    logic tlv;
    logic obsolete;
    logic vendor;
    logic implicitLogin;
    logic [RX_SIZE_W-1:0] rxSize;
    ecc_pkg::ecc_action_t action;
  } ecc_regs_t;

  ecc_regs_t cur_ff;
  ecc_regs_t nxt_cur;
  logic [7:0] liveCode;
  logic [23:0] liveSrc;
  logic [23:0] liveDst;
  logic seqDone;
  logic decKnown;
  ecc_pkg::ecc_login_t decLogin;
  logic decTlv;
  logic decObsolete;
  logic decVendor;
  logic needLogin;
  logic loggedOk;
  logic implicitLogin;
  logic [RX_SIZE_W-1:0] rxSize;

  // the first word carries the code; later words reuse the held copy
  assign liveCode = firstWord ? wordData[ecc_pkg::CODE_MSB:ecc_pkg::CODE_LSB] : cur_ff.code;
  assign liveSrc = firstWord ? srcId : cur_ff.src;
  assign liveDst = firstWord ? dstId : cur_ff.dst;
  assign seqDone = wordValid && seqEnd && (firstWord || (cur_ff.st == ecc_pkg::ST_COLLECT));

  ecc_code_decode i_ecc_code_decode (
    .code(liveCode),
    .known(decKnown),
    .loginCls(decLogin),
    .tlv(decTlv),
    .obsolete(decObsolete),
    .vendor(decVendor)
  );

  ecc_login_resolve #(
    .RX_SIZE_W(RX_SIZE_W)
  ) i_ecc_login_resolve (
    .loginCls(decLogin),
    .srcId(liveSrc),
    .dstId(liveDst),
    .srcLoggedIn(srcLoggedIn),
    .fabricLoggedIn(fabricLoggedIn),
    .authNeedsLogin(authNeedsLogin),
    .portRxSize(portRxSize),
    .fabricRxSize(fabricRxSize),
    .needLogin(needLogin),
    .loggedOk(loggedOk),
    .implicitLogin(implicitLogin),
    .rxSize(rxSize)
  );

  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.valid = 1'b0;
    if (wordValid && firstWord) begin
      // a fresh first word restarts, dropping any unfinished sequence
      nxt_cur.st = ecc_pkg::ST_COLLECT;
      nxt_cur.code = liveCode;
      nxt_cur.src = srcId;
      nxt_cur.dst = dstId;
    end
    if (seqDone) begin
      nxt_cur.st = ecc_pkg::ST_IDLE;
      nxt_cur.valid = 1'b1;
      nxt_cur.outCode = liveCode;
      nxt_cur.known = decKnown;
      nxt_cur.needLogin = decKnown && needLogin;
      nxt_cur.tlv = decKnown && decTlv;
      nxt_cur.obsolete = decObsolete;
      nxt_cur.vendor = decVendor;
      nxt_cur.implicitLogin = decKnown && implicitLogin;
      nxt_cur.rxSize = rxSize;
      // initiative check wins over everything: no reply can be sent anyway
      if (!siXfer) begin
        nxt_cur.action = ecc_pkg::ACT_ABORT;
      end else if (!decKnown) begin
        nxt_cur.action = ecc_pkg::ACT_UNRECOG;
      end else if (needLogin && !loggedOk) begin
        nxt_cur.action = replyDefined ? ecc_pkg::ACT_LOGO_RJT : ecc_pkg::ACT_DISCARD;
      end else begin
        nxt_cur.action = ecc_pkg::ACT_DISPATCH;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign resValid = cur_ff.valid;
  assign resCode = cur_ff.outCode;
  assign resKnown = cur_ff.known;
  assign resNeedLogin = cur_ff.needLogin;
  assign resTlv = cur_ff.tlv;
  assign resObsolete = cur_ff.obsolete;
  assign resVendor = cur_ff.vendor;
  assign resImplicit = cur_ff.implicitLogin;
  assign resRxSize = cur_ff.rxSize;
  assign resAction = cur_ff.action;
  assign busy = (cur_ff.st == ecc_pkg::ST_COLLECT);

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_done_result: assert property (seqDone |=> resValid && resCode == $past(liveCode))
    else $error("sequence end gave no result");
  a_prli_login: assert property (resValid && resCode == ecc_pkg::CMD_PROC_LOGIN
    |-> resNeedLogin && !resTlv)
    else $error("process login class wrong");
  a_disc_login: assert property (resValid && resCode == ecc_pkg::CMD_ADDR_DISC
    |-> resNeedLogin)
    else $error("discovery login class wrong");
  a_report_login: assert property (resValid && resCode == ecc_pkg::CMD_ULP_REPORT
    |-> resNeedLogin)
    else $error("report login class wrong");
  a_notify_free: assert property (resValid && resCode == ecc_pkg::CMD_CLK_UPD
    |-> resKnown && !resNeedLogin)
    else $error("notification needs no login");
  a_loop_old: assert property (resValid && resCode == ecc_pkg::CMD_LOOP_CTRL_OLD
    |-> resObsolete && !resNeedLogin)
    else $error("obsolete loop code wrong");
  a_incident_login: assert property (resValid && resCode == ecc_pkg::CMD_INC_LAST
    |-> resNeedLogin)
    else $error("incident group login wrong");
  a_topo_login: assert property (resValid && resCode == ecc_pkg::CMD_TOPO_LAST
    |-> resNeedLogin && !resTlv)
    else $error("topology code login wrong");
  a_tlv_codes: assert property (resValid && (resCode == ecc_pkg::CMD_DIAG_REG
    || resCode == ecc_pkg::CMD_PRIO_QUERY) |-> resTlv && !resNeedLogin)
    else $error("tlv command class wrong");
  a_cond_fport: assert property (seqDone && firstWord && liveCode == ecc_pkg::CMD_VE_MAP
    && dstId == ecc_pkg::FPORT_CTRL_ID |=> !resNeedLogin && resTlv)
    else $error("fport destination still needs login");
  a_implicit_size: assert property (seqDone && firstWord && liveCode == ecc_pkg::CMD_DIAG_REG
    && srcId == ecc_pkg::FABRIC_CTRL_ID && fabricLoggedIn
    |=> resImplicit && resRxSize == $past(fabricRxSize))
    else $error("implicit login not applied");
  a_legacy_rsvd: assert property (resValid && resCode == ecc_pkg::CMD_LEGACY_RSVD
    |-> !resKnown)
    else $error("legacy code was assigned");
  a_unknown_flag: assert property (resValid && !resKnown |-> resAction == ecc_pkg::ACT_UNRECOG
    || resAction == ecc_pkg::ACT_ABORT)
    else $error("unknown code dispatched");
  a_abort_si: assert property (seqDone && !siXfer |=> resAction == ecc_pkg::ACT_ABORT)
    else $error("missing initiative not aborted");
  a_login_act: assert property (seqDone && siXfer && firstWord
    && liveCode == ecc_pkg::CMD_PROC_LOGIN && !srcLoggedIn
    |=> resAction == ($past(replyDefined) ? ecc_pkg::ACT_LOGO_RJT : ecc_pkg::ACT_DISCARD))
    else $error("unlogged sender handled wrongly");

  c_dispatch: cover property (resValid && resAction == ecc_pkg::ACT_DISPATCH);
  c_abort: cover property (resValid && resAction == ecc_pkg::ACT_ABORT);
  c_multiword: cover property (wordValid && firstWord && !seqEnd ##1 seqDone);
  c_implicit: cover property (resValid && resImplicit);
endmodule // ecc_classifier

/* bench/ecc_far_port.sv */
// far-side port model: sends link service request sequences word by word
module ecc_far_port (
  // clock
  input wire logic clock,
  // request words toward the classifier
  output logic wordValid,
  output logic [31:0] wordData,
  output logic firstWord,
  output logic seqEnd,
  output logic siXfer,
  output logic [23:0] srcId,
  output logic [23:0] dstId,
  output logic replyDefined
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wordValid = 1'b0;
    wordData = 32'h5a5a5a5a;
    firstWord = 1'b0;
    seqEnd = 1'b0;
    siXfer = 1'b0;
    srcId = 24'h0f0f0f;
    dstId = 24'hf0f0f0;
    replyDefined = 1'b0;
  end
  // released lines flip rather than hold, so stale values cannot pass for good ones
  task automatic idle();
    wordValid = 1'b0;
    firstWord = 1'b0;
    seqEnd = 1'b0;
    wordData = ~wordData;
    siXfer = ~siXfer;
    srcId = ~srcId;
    dstId = ~dstId;
    replyDefined = ~replyDefined;
  endtask
  // called at a falling edge; returns one falling edge after the last word, still driving it
  task automatic send(input logic [7:0] code, input int nWords, input int stall, input logic si,
                      input logic first, input logic last, input logic [23:0] src,
                      input logic [23:0] dst, input logic reply);
    for (int i = 0; i < nWords; i++) begin
      for (int s = 0; i > 0 && s < stall; s++) begin
        idle();
        @(negedge clock);
      end
      wordValid = 1'b1;
      firstWord = first && (i == 0);
      seqEnd = last && (i == nWords - 1);
      wordData = (i == 0) ? {code, 24'h3c0f1e} : {8'(i), 24'ha5c3e1};
      srcId = src;
      dstId = dst;
      siXfer = si && (i == nWords - 1);
      replyDefined = reply;
      @(negedge clock);
    end
  endtask
endmodule // ecc_far_port

/* bench/ecc_classifier_bench.sv */
// self-checking bench for the link service request classifier
module ecc_classifier_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RXW = 12;
  localparam logic [23:0] PA = 24'h010203;
  localparam logic [23:0] PB = 24'h040506;
  localparam logic [23:0] FAB = ecc_pkg::FABRIC_CTRL_ID;
  logic clock, sys_rst, wordValid, firstWord, seqEnd, siXfer, replyDefined;
  logic [31:0] wordData;
  logic [23:0] srcId, dstId;
  logic srcLoggedIn, fabricLoggedIn, authNeedsLogin;
  logic [RXW-1:0] portRxSize, fabricRxSize, resRxSize;
  logic resValid, resKnown, resNeedLogin, resTlv, resObsolete, resVendor, resImplicit, busy;
  logic [7:0] resCode;
  ecc_pkg::ecc_action_t resAction;
  int fails, nCompared;

  ecc_far_port i_ecc_far_port (.clock(clock), .wordValid(wordValid), .wordData(wordData),
    .firstWord(firstWord), .seqEnd(seqEnd), .siXfer(siXfer), .srcId(srcId), .dstId(dstId),
    .replyDefined(replyDefined));
  ecc_classifier #(.RX_SIZE_W(RXW)) i_ecc_classifier (.clock(clock), .sys_rst(sys_rst),
    .wordValid(wordValid), .wordData(wordData), .firstWord(firstWord), .seqEnd(seqEnd),
    .siXfer(siXfer), .srcId(srcId), .dstId(dstId), .replyDefined(replyDefined),
    .srcLoggedIn(srcLoggedIn), .fabricLoggedIn(fabricLoggedIn), .authNeedsLogin(authNeedsLogin),
    .portRxSize(portRxSize), .fabricRxSize(fabricRxSize), .resValid(resValid),
    .resCode(resCode), .resKnown(resKnown), .resNeedLogin(resNeedLogin), .resTlv(resTlv),
    .resObsolete(resObsolete), .resVendor(resVendor), .resImplicit(resImplicit),
    .resRxSize(resRxSize), .resAction(resAction), .busy(busy));

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic mism(input string what);
    fails++;
    $display("Error at %0t: %s mismatch", $time, what);
  endtask
  task automatic cmpBit(input logic got, input logic exp, input string what);
    nCompared++;
    if (got !== exp) mism(what);
  endtask
  task automatic cmpCode(input logic [7:0] got, input logic [7:0] exp);
    nCompared++;
    if (got !== exp) mism("code");
  endtask
  task automatic cmpSize(input logic [RXW-1:0] got, input logic [RXW-1:0] exp);
    nCompared++;
    if (got !== exp) mism("rx size");
  endtask
  task automatic cmpAct(input ecc_pkg::ecc_action_t got, input ecc_pkg::ecc_action_t exp);
    nCompared++;
    if (got !== exp) mism("action");
  endtask

  // {known, login needed, tlv}
  function automatic logic [2:0] expCls(input logic [7:0] c, input logic [23:0] dst);
    case (c) inside
      8'h20, 8'h21, 8'h23, 8'h24, 8'h50, 8'h51, 8'h52, 8'h58, 8'h63: expCls = 3'b110;
      [8'h79:8'h7d], [8'ha0:8'ha6]: expCls = 3'b110;
      8'h19, 8'hb0: expCls = 3'b101;
      8'hb1: expCls = {1'b1, dst != ecc_pkg::FPORT_CTRL_ID, 1'b1};
      8'h90: expCls = {1'b1, authNeedsLogin, 1'b0};
      8'h60, 8'h61, 8'h62, 8'h68, 8'h69, 8'h70, 8'h71, 8'h72: expCls = 3'b100;
      8'h77, 8'h78, 8'h7e, 8'h7f, 8'h80, 8'h81, 8'h97: expCls = 3'b100;
      default: expCls = 3'b000;
    endcase
  endfunction

  task automatic checkRes(input logic [7:0] c, input logic si, input logic [23:0] src,
                          input logic [23:0] dst, input logic reply);
    logic [2:0] cls;
    logic imp;
    ecc_pkg::ecc_action_t act;
    cls = expCls(c, dst);
    imp = (c == 8'h19) && fabricLoggedIn && (src == FAB || dst == FAB);
    if (!si) act = ecc_pkg::ACT_ABORT;
    else if (!cls[2]) act = ecc_pkg::ACT_UNRECOG;
    else if (cls[1] && !(srcLoggedIn || imp)) act = reply ? ecc_pkg::ACT_LOGO_RJT : ecc_pkg::ACT_DISCARD;
    else act = ecc_pkg::ACT_DISPATCH;
    cmpBit(resValid, 1'b1, "valid");
    cmpCode(resCode, c);
    cmpBit(resKnown, cls[2], "known");
    cmpBit(resNeedLogin, cls[1], "login");
    cmpBit(resTlv, cls[0], "tlv");
    cmpBit(resObsolete, c == 8'h71, "obsolete");
    cmpBit(resVendor, c == 8'h77, "vendor");
    cmpBit(resImplicit, imp, "implicit");
    cmpSize(resRxSize, imp ? fabricRxSize : portRxSize);
    cmpAct(resAction, act);
  endtask

  task automatic req(input logic [7:0] c, input int n, input int stall, input logic si,
                     input logic [23:0] src, input logic [23:0] dst, input logic reply);
    i_ecc_far_port.send(c, n, stall, si, 1'b1, 1'b1, src, dst, reply);
    checkRes(c, si, src, dst, reply);
  endtask

  task automatic done(input string name);
    i_ecc_far_port.idle();
    @(negedge clock);
    $display("test %s finished", name);
  endtask

  // every code back to back, sender not logged in, with and without a reply
  task automatic sweepCodes();
    srcLoggedIn = 1'b0;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 256; c++) req(8'(c), 1, 0, 1'b1, PA, PB, p == 0);
    end
    done("sweep");
  endtask

  task automatic condLogin();
    req(8'hb1, 1, 0, 1'b1, PA, ecc_pkg::FPORT_CTRL_ID, 1'b1);
    req(8'hb1, 1, 0, 1'b1, PA, PB, 1'b1);
    authNeedsLogin = 1'b1;
    req(8'h90, 2, 0, 1'b1, PA, PB, 1'b1);
    srcLoggedIn = 1'b1;
    req(8'h20, 1, 0, 1'b1, PA, PB, 1'b1);
    req(8'hb1, 1, 0, 1'b1, PA, PB, 1'b0);
    srcLoggedIn = 1'b0;
    authNeedsLogin = 1'b0;
    req(8'h90, 1, 0, 1'b1, PA, PB, 1'b1);
    done("conditional login");
  endtask

  task automatic implicitLogin();
    fabricLoggedIn = 1'b1;
    portRxSize = 12'h100;
    fabricRxSize = 12'h840;
    req(8'h19, 1, 0, 1'b1, FAB, PB, 1'b1);
    req(8'h19, 3, 1, 1'b1, PA, FAB, 1'b1);
    req(8'h19, 1, 0, 1'b1, PA, PB, 1'b1);
    req(8'h20, 1, 0, 1'b1, FAB, PB, 1'b1);
    fabricLoggedIn = 1'b0;
    done("implicit login");
  endtask

  // slow sender, stalls between words, and two sequences without initiative handover
  task automatic noInitiative();
    srcLoggedIn = 1'b1;
    req(8'h20, 4, 2, 1'b0, PA, PB, 1'b1);
    req(8'h7e, 1, 0, 1'b0, PA, PB, 1'b1);
    req(8'ha3, 5, 3, 1'b1, PA, PB, 1'b1);
    i_ecc_far_port.idle();
    @(negedge clock);
    cmpBit(resValid, 1'b0, "pulse");
    cmpCode(resCode, 8'ha3);
    srcLoggedIn = 1'b0;
    done("initiative");
  endtask

  task automatic framing();
    i_ecc_far_port.send(8'h20, 1, 0, 1'b1, 1'b0, 1'b1, PA, PB, 1'b1);
    cmpBit(resValid, 1'b0, "orphan end");
    i_ecc_far_port.send(8'h52, 2, 0, 1'b1, 1'b1, 1'b0, PA, PB, 1'b1);
    cmpBit(busy, 1'b1, "busy");
    req(8'h61, 1, 0, 1'b1, PA, PB, 1'b1);
    done("framing");
  endtask

  task automatic midReset();
    i_ecc_far_port.send(8'h20, 1, 0, 1'b1, 1'b1, 1'b0, PA, PB, 1'b1);
    i_ecc_far_port.idle();
    sys_rst = 1'b1;
    @(negedge clock);
    cmpBit(busy, 1'b0, "reset busy");
    cmpBit(resValid, 1'b0, "reset valid");
    cmpCode(resCode, 8'h00);
    cmpAct(resAction, ecc_pkg::ACT_NONE);
    sys_rst = 1'b0;
    @(negedge clock);
    req(8'h7f, 1, 0, 1'b1, PA, PB, 1'b1);
    done("mid reset");
  endtask

  task automatic tally_and_finish();
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mism("timeout");
    tally_and_finish();
  end

  initial begin
    fails = 0;
    nCompared = 0;
    sys_rst = 1'b1;
    srcLoggedIn = 1'b0;
    fabricLoggedIn = 1'b0;
    authNeedsLogin = 1'b0;
    portRxSize = 12'h0a0;
    fabricRxSize = 12'h5f0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    sweepCodes();
    condLogin();
    implicitLogin();
    noInitiative();
    framing();
    midReset();
    tally_and_finish();
  end
endmodule // ecc_classifier_bench
